// file: jtl_pkg.sv
/*
  Shared constants, the mode descriptor type and the mode table of the
  transmit transport and lane-map block.
  Assumes a single clock domain and an AXI4-Lite register port.
*/
package jtl_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_MODE = 5'h04;
  localparam logic [4:0] OFF_MFLEN = 5'h08;
  localparam logic [4:0] OFF_DEVID = 5'h0c;
  localparam logic [4:0] OFF_OVRT0 = 5'h10;
  localparam logic [4:0] OFF_OVRT1 = 5'h14;
  localparam logic [4:0] OFF_STAT = 5'h18;
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_KM1_LSB = 0;
  localparam int STAT_LANES_LSB = 8;
  localparam int STAT_ENC_BIT = 12;
  localparam int STAT_RUN_BIT = 13;
  localparam int STAT_FCNT_LSB = 16;
  localparam logic [6:0] MODE_RST = 7'h3c;
  localparam logic [7:0] MFLEN_RST = 8'h0f;
  localparam logic [7:0] DEVID_RST = 8'h00;
  localparam logic [14:0] OVRT0_RST = 15'h7000;
  localparam logic [14:0] OVRT1_RST = 15'h7800;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int NUM_LINKS = 2;
  localparam int LINK_LANES = 8;
  localparam int RAW_SLOTS = 20;
  localparam int DDC_SLOTS = 4;
  localparam int RAW_W = 12;
  localparam int COMP_W = 15;
  localparam int LANE_W = 64;
  localparam int STREAM_W = 256;
  localparam int K64_BASE = 8 * 32;

  typedef struct packed {
    logic valid;
    logic enc64;
    logic [5:0] decim;
    logic dual;
    logic [3:0] lanes;
    logic [3:0] conv;
    logic [3:0] octets;
    logic [2:0] spf;
    logic [1:0] e_mult;
  } jtl_mode_t;

  function automatic jtl_mode_t jtl_mk(input logic enc64, input logic [5:0] decim,
      input logic dual, input logic [3:0] lanes, input logic [3:0] conv,
      input logic [3:0] octets, input logic [2:0] spf, input logic [1:0] e_mult);
    jtl_mk = '{1'b1, enc64, decim, dual, lanes, conv, octets, spf, e_mult};
  endfunction : jtl_mk

  // unlisted codes come back with valid low
  function automatic jtl_mode_t jtl_mode_lookup(input logic [6:0] code);
    jtl_mode_lookup = '0;
    case (code)
      7'h1e, 7'h1f: jtl_mode_lookup = jtl_mk(1'b1, 6'h01, code[0], 4'h4, 4'h4, 4'h8, 3'h5, 2'h1);
      7'h20, 7'h21: jtl_mode_lookup = jtl_mk(1'b1, 6'h01, code[0], 4'h3, 4'h1, 4'h2, 3'h4, 2'h1);
      7'h38: jtl_mode_lookup = jtl_mk(1'b0, 6'h10, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h0);
      7'h39: jtl_mode_lookup = jtl_mk(1'b0, 6'h10, 1'b1, 4'h2, 4'h2, 4'h2, 3'h1, 2'h0);
      7'h3a: jtl_mode_lookup = jtl_mk(1'b0, 6'h10, 1'b1, 4'h4, 4'h2, 4'h2, 3'h2, 2'h0);
      7'h3b: jtl_mode_lookup = jtl_mk(1'b1, 6'h10, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h1);
      7'h3c: jtl_mode_lookup = jtl_mk(1'b1, 6'h10, 1'b1, 4'h2, 4'h2, 4'h2, 3'h1, 2'h1);
      7'h3d: jtl_mode_lookup = jtl_mk(1'b0, 6'h10, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h0);
      7'h3e: jtl_mode_lookup = jtl_mk(1'b0, 6'h10, 1'b0, 4'h2, 4'h1, 4'h2, 3'h2, 2'h0);
      7'h3f: jtl_mode_lookup = jtl_mk(1'b0, 6'h10, 1'b0, 4'h4, 4'h1, 4'h2, 3'h4, 2'h0);
      7'h40: jtl_mode_lookup = jtl_mk(1'b1, 6'h10, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h1);
      7'h41: jtl_mode_lookup = jtl_mk(1'b1, 6'h10, 1'b0, 4'h2, 4'h1, 4'h2, 3'h2, 2'h1);
      7'h42: jtl_mode_lookup = jtl_mk(1'b0, 6'h20, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h0);
      7'h43: jtl_mode_lookup = jtl_mk(1'b0, 6'h20, 1'b1, 4'h2, 4'h2, 4'h2, 3'h1, 2'h0);
      7'h44: jtl_mode_lookup = jtl_mk(1'b1, 6'h20, 1'b1, 4'h1, 4'h2, 4'h4, 3'h1, 2'h1);
      7'h45: jtl_mode_lookup = jtl_mk(1'b0, 6'h20, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h0);
      7'h46: jtl_mode_lookup = jtl_mk(1'b0, 6'h20, 1'b0, 4'h2, 4'h1, 4'h2, 3'h2, 2'h0);
      7'h47: jtl_mode_lookup = jtl_mk(1'b1, 6'h20, 1'b0, 4'h1, 4'h1, 4'h2, 3'h1, 2'h1);
      default: jtl_mode_lookup = '0;
    endcase
  endfunction : jtl_mode_lookup
endpackage : jtl_pkg

// file: jtl_ovr_flag.sv
/*
  Overrange flags for one complex down-converted sample.
  Assumes two's complement components and unsigned thresholds.
*/
`timescale 1ns/100ps
module jtl_ovr_flag (
  input wire logic [14:0] comp_i,
  input wire logic [14:0] comp_q,
  input wire logic [14:0] thr_zero,
  input wire logic [14:0] thr_one,
  output logic flag_zero,
  output logic flag_one
);
  wire logic [14:0] mag_i = comp_i[14] ? 15'(-comp_i) : comp_i;
  wire logic [14:0] mag_q = comp_q[14] ? 15'(-comp_q) : comp_q;
  wire logic [14:0] mag_max = (mag_i > mag_q) ? mag_i : mag_q;

  assign flag_zero = mag_max > thr_zero;
  assign flag_one = mag_max > thr_one;
endmodule : jtl_ovr_flag

// file: jtl_link_pack.sv
/*
  Frame packer for one link: samples or down-converted words into lane octets.
  Assumes the mode descriptor is stable while frames flow.
*/
`timescale 1ns/100ps
module jtl_link_pack (
  input jtl_pkg::jtl_mode_t mode,
  input wire logic [11:0] raw [jtl_pkg::RAW_SLOTS],
  input wire logic [14:0] comp [jtl_pkg::DDC_SLOTS],
  input wire logic [14:0] thr_zero,
  input wire logic [14:0] thr_one,
  output logic [63:0] lane_word [jtl_pkg::LINK_LANES]
);
  logic [15:0] ddc_word [jtl_pkg::DDC_SLOTS];
  logic [255:0] stream;
  logic [255:0] shifted;
  wire logic bypass = mode.decim == 6'h01;
  // one converter per lane, samples in time order across lanes
  wire logic marked = bypass && mode.conv == mode.lanes && mode.lanes > 4'h1;

  for (genvar p = 0; p < jtl_pkg::DDC_SLOTS / 2; p++) begin : g_pair
    logic f0;
    logic f1;
    jtl_ovr_flag u_ovr (
      .comp_i(comp[2*p]),
      .comp_q(comp[2*p+1]),
      .thr_zero(thr_zero),
      .thr_one(thr_one),
      .flag_zero(f0),
      .flag_one(f1)
    );
    assign ddc_word[2*p] = {comp[2*p], f0};
    assign ddc_word[2*p+1] = {comp[2*p+1], f1};
  end

  always_comb begin
    int items;
    int idx;
    items = int'(mode.conv) * int'(mode.spf);
    idx = 0;
    stream = '0; // tail positions stay zero
    for (int i = 0; i < jtl_pkg::RAW_SLOTS; i++) begin
      if (bypass && i < items) begin
        stream[255-12*i -: 12] = raw[i]; // msb first
      end
    end
    for (int i = 0; i < jtl_pkg::DDC_SLOTS; i++) begin
      if (!bypass && i < items) begin
        stream[255-16*i -: 16] = ddc_word[i];
      end
    end
    shifted = '0;
    for (int l = 0; l < jtl_pkg::LINK_LANES; l++) begin
      lane_word[l] = '0;
      if (l < int'(mode.lanes)) begin
        if (marked) begin
          for (int j = 0; j < 5; j++) begin
            idx = l + int'(mode.lanes) * j;
            if (j < int'(mode.spf) && idx < jtl_pkg::RAW_SLOTS) begin
              lane_word[l][63-12*j -: 12] = raw[idx];
            end
          end
        end else begin
          shifted = stream << (l * int'(mode.octets) * 8);
          lane_word[l] = shifted[255:192] & ~({64{1'b1}} >> (int'(mode.octets) * 8));
        end
      end
    end
  end
endmodule : jtl_link_pack

// file: jtl_tx_transport.sv
/*
  Transmit transport and lane-map block: mode decode, multiframe count,
  identifiers, lane power-down and frame packing for two links of 8 lanes.
  Assumes an AXI4-Lite master and a sample source synchronous to mclk.
*/
`timescale 1ns/100ps
module jtl_tx_transport (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [jtl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [jtl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] bypass_sample [jtl_pkg::NUM_LINKS][jtl_pkg::RAW_SLOTS],
  input wire logic [14:0] ddc_component [jtl_pkg::NUM_LINKS][jtl_pkg::DDC_SLOTS],
  input wire logic smp_valid,
  output logic smp_ready,
  output logic [63:0] lane_data [16],
  output logic lane_data_valid,
  output logic [15:0] lane_powered,
  output logic [2:0] lane_identifier [16],
  output logic [7:0] link_dev_id_a,
  output logic [7:0] link_dev_id_b,
  output logic mframe_start
);
  logic link_en;
  logic [6:0] link_operating_mode_code;
  logic [7:0] multiframe_frames_minus_one;
  logic [7:0] link_device_identifier;
  logic [14:0] overrange_threshold_zero;
  logic [14:0] overrange_threshold_one;
  logic aw_held;
  logic w_held;
  logic [4:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [7:0] frame_cnt;
  logic [63:0] packed_lane [jtl_pkg::NUM_LINKS][jtl_pkg::LINK_LANES];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
      input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  wire jtl_pkg::jtl_mode_t cur = jtl_pkg::jtl_mode_lookup(link_operating_mode_code);

  // write decode
  wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire logic [4:0] waddr = {aw_addr_q[4:2], 2'h0};
  wire logic wr_ctrl = wr_fire && waddr == jtl_pkg::OFF_CTRL;
  wire logic wr_mode = wr_fire && waddr == jtl_pkg::OFF_MODE;
  wire logic wr_mflen = wr_fire && waddr == jtl_pkg::OFF_MFLEN;
  wire logic wr_devid = wr_fire && waddr == jtl_pkg::OFF_DEVID;
  wire logic wr_t0 = wr_fire && waddr == jtl_pkg::OFF_OVRT0;
  wire logic wr_t1 = wr_fire && waddr == jtl_pkg::OFF_OVRT1;
  wire logic wr_stat = wr_fire && waddr == jtl_pkg::OFF_STAT;
  wire logic [31:0] next_ctrl = merge({31'h0, link_en}, w_data_q, w_strb_q);
  wire logic [31:0] next_mflen = merge({24'h0, multiframe_frames_minus_one}, w_data_q, w_strb_q);
  wire logic [31:0] next_devid = merge({24'h0, link_device_identifier}, w_data_q, w_strb_q);
  wire logic [31:0] next_t0 = merge({17'h0, overrange_threshold_zero}, w_data_q, w_strb_q);
  wire logic [31:0] next_t1 = merge({17'h0, overrange_threshold_one}, w_data_q, w_strb_q);
  wire logic [31:0] next_mode_word = merge({25'h0, link_operating_mode_code}, w_data_q,
      w_strb_q);
  wire jtl_pkg::jtl_mode_t next_mode_desc = jtl_pkg::jtl_mode_lookup(next_mode_word[6:0]);
  // codes outside the table or above 7 bits are refused
  wire logic mode_ok = next_mode_desc.valid && next_mode_word[31:7] == 25'h0;
  wire logic wr_bad = (wr_mode && !mode_ok)
      || !(wr_ctrl || wr_mode || wr_mflen || wr_devid || wr_t0 || wr_t1 || wr_stat);

  // effective multiframe length minus one
  wire logic [7:0] k64_m1 = 8'(jtl_pkg::K64_BASE * int'(cur.e_mult) / int'(cur.octets) - 1);
  wire logic [7:0] k_m1 = cur.enc64 ? k64_m1 : multiframe_frames_minus_one;

  wire logic frame_take = smp_valid && smp_ready;
  wire logic [31:0] stat_word = {8'h0, frame_cnt, 2'h0, link_en, cur.enc64, cur.lanes, k_m1};

  // read decode
  wire logic [4:0] raddr = {s_axi_araddr[4:2], 2'h0};
  wire logic rd_mapped = raddr <= jtl_pkg::OFF_STAT;
  wire logic [31:0] rd_mux =
      raddr == jtl_pkg::OFF_CTRL ? {31'h0, link_en} :
      raddr == jtl_pkg::OFF_MODE ? {25'h0, link_operating_mode_code} :
      raddr == jtl_pkg::OFF_MFLEN ? {24'h0, multiframe_frames_minus_one} :
      raddr == jtl_pkg::OFF_DEVID ? {24'h0, link_device_identifier} :
      raddr == jtl_pkg::OFF_OVRT0 ? {17'h0, overrange_threshold_zero} :
      raddr == jtl_pkg::OFF_OVRT1 ? {17'h0, overrange_threshold_one} :
      raddr == jtl_pkg::OFF_STAT ? stat_word : 32'h0;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;
  assign smp_ready = link_en;
  assign link_dev_id_a = link_device_identifier;
  assign link_dev_id_b = link_device_identifier + 8'h01;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr_q <= 5'h0;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= jtl_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_bad ? jtl_pkg::RESP_SLVERR : jtl_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= jtl_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_mapped ? jtl_pkg::RESP_OKAY : jtl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      link_en <= 1'b0;
      link_operating_mode_code <= jtl_pkg::MODE_RST;
      multiframe_frames_minus_one <= jtl_pkg::MFLEN_RST;
      link_device_identifier <= jtl_pkg::DEVID_RST;
      overrange_threshold_zero <= jtl_pkg::OVRT0_RST;
      overrange_threshold_one <= jtl_pkg::OVRT1_RST;
    end else begin
      if (wr_ctrl) begin
        link_en <= next_ctrl[jtl_pkg::CTRL_EN_BIT];
      end
      if (wr_mode && mode_ok) begin
        link_operating_mode_code <= next_mode_word[6:0];
      end
      // stored in every mode, used only where the encoding allows it
      if (wr_mflen) begin
        multiframe_frames_minus_one <= next_mflen[7:0];
      end
      if (wr_devid) begin
        link_device_identifier <= next_devid[7:0];
      end
      if (wr_t0) begin
        overrange_threshold_zero <= next_t0[14:0];
      end
      if (wr_t1) begin
        overrange_threshold_one <= next_t1[14:0];
      end
    end
  end

  // both links always built and driven
  for (genvar k = 0; k < jtl_pkg::NUM_LINKS; k++) begin : g_link
    jtl_link_pack u_pack (
      .mode(cur),
      .raw(bypass_sample[k]),
      .comp(ddc_component[k]),
      .thr_zero(overrange_threshold_zero),
      .thr_one(overrange_threshold_one),
      .lane_word(packed_lane[k])
    );
    for (genvar l = 0; l < jtl_pkg::LINK_LANES; l++) begin : g_lane
      logic lane_on;
      assign lane_identifier[k*jtl_pkg::LINK_LANES+l] = 3'(l);
      assign lane_powered[k*jtl_pkg::LINK_LANES+l] = lane_on;
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          lane_on <= 1'b0;
          lane_data[k*jtl_pkg::LINK_LANES+l] <= 64'h0;
        end else begin
          lane_on <= link_en && l < int'(cur.lanes);
          if (!link_en) begin
            lane_data[k*jtl_pkg::LINK_LANES+l] <= 64'h0;
          end else if (frame_take) begin
            lane_data[k*jtl_pkg::LINK_LANES+l] <= packed_lane[k][l];
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      frame_cnt <= 8'h0;
      mframe_start <= 1'b0;
      lane_data_valid <= 1'b0;
    end else begin
      lane_data_valid <= frame_take;
      mframe_start <= frame_take && frame_cnt == 8'h0;
      if (!link_en) begin
        frame_cnt <= 8'h0;
      end else if (frame_take) begin
        frame_cnt <= (frame_cnt >= k_m1) ? 8'h0 : frame_cnt + 8'h01;
      end
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_frame_taken;
    smp_valid && smp_ready;
  endsequence

  sequence s_bad_mode_write;
    wr_mode && !mode_ok;
  endsequence

  a_mode_refused: assert property (s_bad_mode_write |=>
      $stable(link_operating_mode_code) && s_axi_bresp == jtl_pkg::RESP_SLVERR)
    else $error("refused mode code changed the mode");

  a_k_fixed_long: assert property (cur.enc64 |->
      (int'(k_m1) + 1) * int'(cur.octets) == 256 * int'(cur.e_mult))
    else $error("64b/66b multiframe length wrong");

  a_k_programmed: assert property (s_frame_taken and (!cur.enc64 && link_en
      && frame_cnt == multiframe_frames_minus_one) |=> frame_cnt == 8'h0)
    else $error("multiframe did not wrap at programmed length");

  a_mframe_pulse: assert property (mframe_start |-> $past(frame_cnt) == 8'h0
      && lane_data_valid)
    else $error("multiframe start without first frame");

  a_links_match: assert property (lane_powered[7:0] == lane_powered[15:8])
    else $error("links use different lane sets");

  a_lanes_lowest: assert property (##1 lane_powered[0] == $past(link_en)
      && (lane_powered[7:0] & (lane_powered[7:0] + 8'h01)) == 8'h0)
    else $error("powered lanes not lowest contiguous");

  a_link_b_id: assert property (link_dev_id_b == 8'(link_dev_id_a + 8'h01))
    else $error("link B identifier not link A plus one");

  a_lane_ident: assert property (lane_identifier[13] == 3'h5
      && lane_identifier[2] == 3'h2)
    else $error("lane identifier not lane position");

  a_bypass_msb: assert property (s_frame_taken and (cur.decim == 6'h01 && !cur.conv[2]) |=>
      lane_data[0][63:52] == $past(bypass_sample[0][0]))
    else $error("bypass sample not msb first in octet zero");

  a_ddc_word: assert property (s_frame_taken and (cur.decim != 6'h01) |=>
      lane_data[8][63:49] == $past(ddc_component[1][0]))
    else $error("down-converted component misplaced");

  a_tail_zero: assert property (lane_data_valid && cur.conv == 4'h4 && cur.decim == 6'h01 |->
      lane_data[3][3:0] == 4'h0)
    else $error("tail bits not zero");

  a_mode_shape: assert property (link_operating_mode_code == 7'h3c |-> cur.enc64
      && cur.lanes == 4'h2 && cur.dual && k_m1 == 8'h7f)
    else $error("mode 60 shape wrong");

  a_mode_narrow: assert property (link_operating_mode_code == 7'h3f |-> !cur.enc64
      && cur.lanes == 4'h4 && cur.decim == 6'h10 && !cur.dual && cur.spf == 3'h4)
    else $error("mode 63 shape wrong");

  a_mode_dual32: assert property (link_operating_mode_code == 7'h43 |-> !cur.enc64
      && cur.conv == 4'h2 && cur.decim == 6'h20 && k_m1 == multiframe_frames_minus_one)
    else $error("mode 67 shape wrong");
endmodule : jtl_tx_transport

// file: jtl_rx_model.sv
/*
  Receiving end of both links: counts delivered frames, watches idle lanes.
  Assumes lane_data holds from one valid pulse until the next frame.
*/
`timescale 1ns/100ps
module jtl_rx_model (
  input wire logic mclk,
  input wire logic [63:0] lane_data [16],
  input wire logic lane_data_valid,
  input wire logic [3:0] lanes_used,
  output int frames,
  output logic [59:0] rebuilt,
  output logic stray
);
  initial frames = 0;
  initial stray = 1'b0;
  // only the lowest lanes of each link are read, the rest must stay quiet
  always @(posedge mclk) begin
    if (lane_data_valid) begin
      frames <= frames + 1;
      // link A samples back in time order: lane first, then position in the lane
      for (int n = 0; n < 5; n++)
        if (lanes_used != 0)
          rebuilt[59-12*n -: 12] <= lane_data[n % lanes_used][63-12*(n/lanes_used) -: 12];
      for (int i = 0; i < 16; i++)
        if (i % 8 >= lanes_used && lane_data[i] !== '0) stray <= 1'b1;
    end
  end
endmodule : jtl_rx_model

// file: jtl_tx_transport_tb_top.sv
/*
  Self-checking bench of the transport and lane-map block.
  Assumes an AXI4-Lite master here and the receiver model on the lanes.
*/
`timescale 1ns/100ps
module jtl_tx_transport_tb_top;
  logic mclk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic smp_valid = 0, awready, wready, bvalid, arready, rvalid, smp_ready, ldv, mfs, stray;
  logic [4:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, seed = 32'hc3486312;
  logic [1:0] bresp, rresp, r;
  logic [11:0] sb [2][20], pb [2][20];
  logic [14:0] sc [2][4], pc [2][4];
  logic [14:0] t0 = 15'h2000, t1 = 15'h3000;
  logic [63:0] ld [16];
  logic [15:0] lp;
  logic [2:0] lane_ids [16];
  logic [7:0] ida, idb;
  logic [59:0] reb;
  logic [3:0] lanes = 0;
  int err_total = 0, checked = 0, cyc = 0, frames, total = 0;
  always #2.5 mclk = ~mclk;
  jtl_tx_transport dut_u (.mclk(mclk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bypass_sample(sb), .ddc_component(sc), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .lane_data(ld), .lane_data_valid(ldv), .lane_powered(lp), .lane_identifier(lane_ids),
    .link_dev_id_a(ida), .link_dev_id_b(idb), .mframe_start(mfs));
  jtl_rx_model rx_u (.mclk(mclk), .lane_data(ld), .lane_data_valid(ldv),
    .lanes_used(lanes), .frames(frames), .rebuilt(reb), .stray(stray));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      print_verdict();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [14:0] mag(input logic [14:0] x);
    mag = x[14] ? 15'(-x) : x;
  endfunction : mag
  function automatic logic [63:0] exp_lane(input int k, input int l, input int kd, input int ln);
    logic [14:0] a, b;
    logic [63:0] s;
    exp_lane = '0;
    if (l >= ln) return exp_lane;
    a = mag(pc[k][l & 2]);
    b = mag(pc[k][(l & 2) + 1]);
    s = {pb[k][0], pb[k][1], pb[k][2], pb[k][3], 16'h0};
    if (kd == 2)
      for (int m = 0; m < 5; m++) exp_lane[63 - 12 * m -: 12] = pb[k][l + 4 * m];
    else if (kd == 1)
      exp_lane[63 -: 16] = s[63 - 16 * l -: 16];
    else
      exp_lane[63 -: 16] = {pc[k][l], ((a > b) ? a : b) > ((l % 2) ? t1 : t0)};
  endfunction : exp_lane
  task automatic cmp(input string n, input logic [63:0] e, input logic [63:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic axw(input logic [4:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    rs = bresp;
    bready <= 0;
  endtask : axw
  task automatic axr(input logic [4:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 0;
  endtask : axr
  task automatic run(input int kd, input int ln, input int n, input int k);
    for (int f = 0; f <= n; f++) begin
      @(posedge mclk);
      pb = sb;
      pc = sc;
      for (int i = 0; i < 40; i++) begin
        seed = lfsr(seed);
        sb[i / 20][i % 20] <= seed[11:0];
        if (i < 8) sc[i / 4][i % 4] <= (f == 1 && i < 2) ? t0 : seed[26:12];
      end
      smp_valid <= (f < n);
      #1;
      if (f > 0) begin
        cmp("valid", 1, ldv);
        cmp("mframe", ((f - 1) % k) == 0, mfs);
        for (int i = 0; i < 16; i++)
          cmp("lane", exp_lane(i / 8, i % 8, kd, ln), ld[i]);
      end
    end
  endtask : run
  task automatic mode(input logic [6:0] m, input logic e, input logic [3:0] ln,
      input logic [7:0] km, input int kd);
    axw(5'h00, 0, r);
    axw(5'h04, m, r);
    cmp("mode_resp", 0, r);
    axw(5'h08, 23, r);
    lanes = ln;
    axw(5'h00, 1, r);
    axr(5'h18, d, r);
    cmp("status", {1'b1, e, ln, km}, d[13:0]);
    cmp("powered", {2{8'((1 << ln) - 1)}}, lp);
    total += km + 2;
    run(kd, ln, km + 2, km + 1);
    if (kd == 2) begin
      @(posedge mclk);
      #1;
      cmp("rebuilt", {pb[0][0], pb[0][1], pb[0][2], pb[0][3], pb[0][4]}, reb);
    end
  endtask : mode
  initial begin
    sb = '{default: '0};
    sc = '{default: '0};
    repeat (8) @(posedge mclk);
    rst <= 0;
    axr(5'h04, d, r);
    cmp("mode_reset", 32'h3c, d);
    axr(5'h08, d, r);
    cmp("mflen_reset", 32'h0f, d);
    axr(5'h1c, d, r);
    cmp("unmapped", 2, r);
    cmp("ready_off", 0, smp_ready);
    for (int i = 0; i < 16; i++)
      cmp("lane_id", i % 8, lane_ids[i]);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 32'hff : {24'h0, seed[7:0]};
      axw(5'h0c, d, r);
      cmp("dev_a", d[7:0], ida);
      cmp("dev_b", 8'(d[7:0] + 8'h1), idb);
    end
    axw(5'h04, 32'h22, r);
    cmp("bad_mode", 2, r);
    axr(5'h18, d, r);
    cmp("mode_kept", 2, d[11:8]);
    axw(5'h10, t0, r);
    axw(5'h14, t1, r);
    mode(7'h3c, 1'b1, 4'h2, 8'h7f, 0);
    mode(7'h3f, 1'b0, 4'h4, 8'h17, 0);
    mode(7'h43, 1'b0, 4'h2, 8'h17, 0);
    mode(7'h20, 1'b1, 4'h3, 8'h7f, 1);
    mode(7'h1e, 1'b1, 4'h4, 8'h1f, 2);
    @(posedge mclk);
    #1;
    cmp("rx_frames", total, frames);
    cmp("stray", 0, stray);
    print_verdict();
  end
endmodule : jtl_tx_transport_tb_top
